// ===== rtl/wmclh_top.sv
`timescale 1ns/1ps
module wmclh_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Device side
	input  wire logic        wait_mode_i,
	input  wire logic        wakeup_irq_i,
	input  wire logic        ext_reset_i,
	input  wire logic        clock_monitor_fail_i,
	input  wire logic        oscillator_clock_i,
	output logic             clock_monitor_reset_o,
	output logic             reset_sequence_o,
	output logic             wait_exit_o,
	output logic             self_clock_mode_o,
	output logic             pll_enable_o,
	output logic             voltage_regulator_o,
	output logic             system_clock_pll_o,
	output logic             quality_run_o,
	output logic             irq_o
);
	wmclh_pkg::wmclh_state_t state_q;
	wmclh_pkg::wmclh_state_t state_d;

	logic [wmclh_pkg::CTRL_W-1:0] ctrl_q;
	logic [wmclh_pkg::CTRL_W-1:0] ctrl_d;
	logic [wmclh_pkg::EV_W-1:0]   status_q;
	logic [wmclh_pkg::EV_W-1:0]   status_d;
	logic [wmclh_pkg::EV_W-1:0]   mask_q;
	logic [wmclh_pkg::EV_W-1:0]   mask_d;
	logic [wmclh_pkg::EV_W-1:0]   events;
	logic [wmclh_pkg::EV_W-1:0]   w1c;

	logic [wmclh_pkg::SYNC_N-1:0] pin_raw;
	logic [wmclh_pkg::SYNC_N-1:0] pin_sync;

	logic        fail_s;
	logic        xrst_s;
	logic        osc_s;
	logic        osc_prev_q;
	logic        osc_edge;
	logic        qc_ok;

	logic        clock_monitor_enable;
	logic        self_clock_mode_enable;
	logic        self_clock_interrupt_enable;
	logic        pll_off_in_wait;
	logic        loss;
	logic        leave;

	logic        cmr_d;
	logic        cmr_q;
	logic        rseq_d;
	logic        rseq_q;
	logic        exit_d;
	logic        exit_q;
	logic        pll_d;
	logic        pll_q;
	logic        reg_on_q;
	logic        self_enter;

	logic        wb_req;
	logic        wb_wr;
	logic        wb_rd;
	logic        sel_ctrl;
	logic        sel_status;
	logic        sel_mask;
	logic        sel_state;
	logic [31:0] rd_d;
	logic        ack_q;

	// Pins from other domains pass two flip-flops first
	assign pin_raw = {oscillator_clock_i, ext_reset_i, clock_monitor_fail_i};

	genvar gi;
	generate
		for (gi = 0; gi < wmclh_pkg::SYNC_N; gi++) begin : g_sync
			wmclh_sync2 u_sync (
				.clk_i (clk_i),
				.rst_i (rst_i),
				.d_i   (pin_raw[gi]),
				.q_o   (pin_sync[gi])
			);
		end
	endgenerate

	assign fail_s   = pin_sync[0];
	assign xrst_s   = pin_sync[1];
	assign osc_s    = pin_sync[2];
	// Only slow oscillators are countable; edges closer than two cycles merge
	assign osc_edge = osc_s && !osc_prev_q;

	assign clock_monitor_enable        = ctrl_q[wmclh_pkg::CTRL_MON_EN_BIT];
	assign self_clock_mode_enable      = ctrl_q[wmclh_pkg::CTRL_SELF_EN_BIT];
	assign self_clock_interrupt_enable = ctrl_q[wmclh_pkg::CTRL_SELF_IE_BIT];
	assign pll_off_in_wait             = ctrl_q[wmclh_pkg::CTRL_PLLW_BIT];

	// Loss seen only with monitor enabled
	assign loss  = fail_s && clock_monitor_enable;
	assign leave = wakeup_irq_i || xrst_s;

	assign quality_run_o = (state_q == wmclh_pkg::ST_WAIT_SELF) ||
	                       (state_q == wmclh_pkg::ST_RUN_SELF);

	wmclh_qcheck u_qcheck (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.run_i      (quality_run_o),
		.fail_i     (fail_s),
		.osc_edge_i (osc_edge),
		.ok_o       (qc_ok)
	);

	// Clock loss state machine
	always_comb begin
		state_d = state_q;
		cmr_d   = 1'b0;
		rseq_d  = 1'b0;
		exit_d  = 1'b0;
		case (state_q)
			wmclh_pkg::ST_RUN: begin
				if (wait_mode_i) begin
					state_d = wmclh_pkg::ST_WAIT_OK;
				end
			end
			wmclh_pkg::ST_WAIT_OK: begin
				if (loss && !self_clock_mode_enable) begin
					cmr_d   = 1'b1;
					state_d = wmclh_pkg::ST_RUN;
				end else if (loss) begin
					state_d = wmclh_pkg::ST_WAIT_SELF;
				end else if (leave) begin
					exit_d  = 1'b1;
					rseq_d  = xrst_s;
					state_d = wmclh_pkg::ST_RUN;
				end
			end
			wmclh_pkg::ST_WAIT_SELF: begin
				if (qc_ok) begin
					exit_d  = leave;
					rseq_d  = xrst_s;
					state_d = leave ? wmclh_pkg::ST_RUN : wmclh_pkg::ST_WAIT_OK;
				end else if (leave) begin
					exit_d  = 1'b1;
					rseq_d  = xrst_s;
					state_d = wmclh_pkg::ST_RUN_SELF;
				end
			end
			wmclh_pkg::ST_RUN_SELF: begin
				if (qc_ok) begin
					state_d = wmclh_pkg::ST_RUN;
				end
			end
			default: begin
				state_d = wmclh_pkg::ST_RUN;
			end
		endcase
	end

	assign self_enter = (state_q == wmclh_pkg::ST_WAIT_OK) && loss && self_clock_mode_enable;

	// PLL drops only in plain wait
	assign pll_d = (state_d == wmclh_pkg::ST_WAIT_OK) ? !pll_off_in_wait : 1'b1;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q    <= wmclh_pkg::ST_RUN;
			cmr_q      <= 1'b0;
			rseq_q     <= 1'b0;
			exit_q     <= 1'b0;
			pll_q      <= 1'b1;
			reg_on_q   <= 1'b1;
			osc_prev_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			cmr_q      <= cmr_d;
			rseq_q     <= rseq_d;
			exit_q     <= exit_d;
			pll_q      <= pll_d;
			reg_on_q   <= 1'b1;
			osc_prev_q <= osc_s;
		end
	end

	assign clock_monitor_reset_o = cmr_q;
	assign reset_sequence_o      = rseq_q;
	assign wait_exit_o           = exit_q;
	assign pll_enable_o          = pll_q;
	// Regulator is never switched off in wait
	assign voltage_regulator_o   = reg_on_q;
	assign self_clock_mode_o     = quality_run_o;
	assign system_clock_pll_o    = quality_run_o;

	// Wishbone decode
	assign wb_req     = wb_cyc_i && wb_stb_i && !ack_q;
	assign wb_wr      = wb_req && wb_we_i && wb_sel_i[0];
	assign wb_rd      = wb_req && !wb_we_i;
	assign sel_ctrl   = (wb_adr_i == wmclh_pkg::ADDR_CTRL);
	assign sel_status = (wb_adr_i == wmclh_pkg::ADDR_STATUS);
	assign sel_mask   = (wb_adr_i == wmclh_pkg::ADDR_MASK);
	assign sel_state  = (wb_adr_i == wmclh_pkg::ADDR_STATE);

	assign ctrl_d = (wb_wr && sel_ctrl) ? wb_dat_i[wmclh_pkg::CTRL_W-1:0] : ctrl_q;
	assign mask_d = (wb_wr && sel_mask) ? wb_dat_i[wmclh_pkg::EV_W-1:0] : mask_q;
	assign w1c    = (wb_wr && sel_status) ? wb_dat_i[wmclh_pkg::EV_W-1:0] : 4'h0;

	assign events[wmclh_pkg::EV_SELF_BIT] = self_enter;
	assign events[wmclh_pkg::EV_QOK_BIT]  = qc_ok;
	assign events[wmclh_pkg::EV_CMR_BIT]  = cmr_d;
	assign events[wmclh_pkg::EV_EXIT_BIT] = exit_d;

	// Sticky flags, a new event beats the clear
	assign status_d = (status_q & ~w1c) | events;

	// Unmapped offsets read as zero and still acknowledge
	assign rd_d = sel_ctrl   ? {28'h0000000, ctrl_q} :
	              sel_status ? {28'h0000000, status_q} :
	              sel_mask   ? {28'h0000000, mask_q} :
	              sel_state  ? {25'h0000000, pll_q, reg_on_q, quality_run_o,
	                            wait_mode_i, qc_ok, state_q} :
	              32'h00000000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q   <= wmclh_pkg::CTRL_RESET;
			status_q <= wmclh_pkg::EV_RESET;
			mask_q   <= wmclh_pkg::EV_RESET;
			ack_q    <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			ctrl_q   <= ctrl_d;
			status_q <= status_d;
			mask_q   <= mask_d;
			ack_q    <= wb_req;
			wb_dat_o <= wb_rd ? rd_d : wb_dat_o;
		end
	end

	assign wb_ack_o = ack_q;

	// Self-clock interrupt enable also forces its flag through
	assign irq_o = |(status_q & mask_q) ||
	               (self_clock_interrupt_enable && status_q[wmclh_pkg::EV_SELF_BIT]);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_loss_ignored: assert property (
		(state_q == wmclh_pkg::ST_WAIT_OK && !clock_monitor_enable && !leave)
		|=> state_q == wmclh_pkg::ST_WAIT_OK && !clock_monitor_reset_o && !self_clock_mode_o)
		else $error("clock loss acted on with monitor disabled");

	chk_cm_reset: assert property (
		(state_q == wmclh_pkg::ST_WAIT_OK && fail_s && clock_monitor_enable
		 && !self_clock_mode_enable)
		|=> clock_monitor_reset_o && state_q == wmclh_pkg::ST_RUN)
		else $error("monitor reset missing");

	chk_self_entry: assert property (
		(state_q == wmclh_pkg::ST_WAIT_OK && fail_s && clock_monitor_enable
		 && self_clock_mode_enable)
		|=> state_q == wmclh_pkg::ST_WAIT_SELF && self_clock_mode_o && pll_enable_o
		    && voltage_regulator_o && status_q[wmclh_pkg::EV_SELF_BIT] && quality_run_o)
		else $error("self-clock entry incomplete");

	chk_qc_leave: assert property (
		(state_q == wmclh_pkg::ST_WAIT_SELF && qc_ok && !leave)
		|=> state_q == wmclh_pkg::ST_WAIT_OK && !self_clock_mode_o && voltage_regulator_o
		    && pll_enable_o == !$past(pll_off_in_wait))
		else $error("quality pass did not end self-clock properly");

	chk_wake_osc: assert property (
		(state_q == wmclh_pkg::ST_WAIT_OK && wakeup_irq_i && !xrst_s && !loss
		 && !w1c[wmclh_pkg::EV_SELF_BIT])
		|=> wait_exit_o && !system_clock_pll_o && !reset_sequence_o
		    && $stable(status_q[wmclh_pkg::EV_SELF_BIT]))
		else $error("wakeup exit not on oscillator clock");

	chk_xrst_osc: assert property (
		(state_q == wmclh_pkg::ST_WAIT_OK && xrst_s && !loss)
		|=> reset_sequence_o && wait_exit_o && !system_clock_pll_o)
		else $error("external reset exit wrong");

	chk_checks_repeat: assert property (
		(state_q == wmclh_pkg::ST_WAIT_SELF && !qc_ok && !leave)
		|=> state_q == wmclh_pkg::ST_WAIT_SELF && quality_run_o)
		else $error("quality checks stopped in wait");

	chk_wake_pll: assert property (
		(state_q == wmclh_pkg::ST_WAIT_SELF && !qc_ok && wakeup_irq_i && !xrst_s)
		|=> state_q == wmclh_pkg::ST_RUN_SELF && system_clock_pll_o && quality_run_o
		    && wait_exit_o ##1 (quality_run_o || $past(qc_ok)))
		else $error("wakeup exit from self-clock wrong");

	chk_xrst_pll: assert property (
		(state_q == wmclh_pkg::ST_WAIT_SELF && !qc_ok && xrst_s)
		|=> reset_sequence_o && system_clock_pll_o && quality_run_o)
		else $error("external reset exit from self-clock wrong");

	chk_flag_sticky: assert property (
		(status_q[wmclh_pkg::EV_SELF_BIT] && !w1c[wmclh_pkg::EV_SELF_BIT])
		|=> status_q[wmclh_pkg::EV_SELF_BIT])
		else $error("self-clock flag lost");

	cov_cm_reset: cover property (clock_monitor_reset_o);
	cov_recover: cover property (state_q == wmclh_pkg::ST_WAIT_SELF ##1
		state_q == wmclh_pkg::ST_WAIT_OK);
	cov_exit_pll: cover property (wait_exit_o && system_clock_pll_o);
	cov_run_self_done: cover property (state_q == wmclh_pkg::ST_RUN_SELF ##1
		state_q == wmclh_pkg::ST_RUN);

endmodule // wmclh_top

// ===== shared/wmclh_pkg.sv
package wmclh_pkg;

	// Register byte offsets on the Wishbone slave
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_MASK   = 4'h8;
	localparam logic [3:0] ADDR_STATE  = 4'hc;

	// Control register fields
	localparam int CTRL_MON_EN_BIT  = 0;
	localparam int CTRL_SELF_EN_BIT = 1;
	localparam int CTRL_SELF_IE_BIT = 2;
	localparam int CTRL_PLLW_BIT    = 3;
	localparam int CTRL_W           = 4;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	// Status and mask fields, same layout
	localparam int EV_SELF_BIT = 0;
	localparam int EV_QOK_BIT  = 1;
	localparam int EV_CMR_BIT  = 2;
	localparam int EV_EXIT_BIT = 3;
	localparam int EV_W        = 4;
	localparam logic [3:0] EV_RESET = 4'h0;

	// Oscillator cycles for one clock quality check
	localparam int QC_CYCLES = 4096;
	localparam int QC_W      = 12;
	localparam logic [11:0] QC_LAST = 12'(QC_CYCLES - 1);
	localparam logic [11:0] QC_ZERO = 12'h000;

	// Number of synchronised pin inputs
	localparam int SYNC_N = 3;

	typedef enum logic [1:0] {
		ST_RUN       = 2'h0,
		ST_WAIT_OK   = 2'h1,
		ST_WAIT_SELF = 2'h3,
		ST_RUN_SELF  = 2'h2
	} wmclh_state_t;

endpackage

// ===== rtl/wmclh_sync2.sv
`timescale 1ns/1ps
module wmclh_sync2 (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic meta_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= 1'b0;
			q_o    <= 1'b0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule // wmclh_sync2

// ===== rtl/wmclh_qcheck.sv
`timescale 1ns/1ps
module wmclh_qcheck (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic run_i,
	input  wire logic fail_i,
	input  wire logic osc_edge_i,
	output logic      ok_o
);
	logic [wmclh_pkg::QC_W-1:0] cnt_q;
	logic [wmclh_pkg::QC_W-1:0] cnt_d;
	logic                       hit;

	// A failing monitor restarts the check, so checks repeat endlessly
	assign hit   = run_i && !fail_i && osc_edge_i && (cnt_q == wmclh_pkg::QC_LAST);
	assign cnt_d = (!run_i || fail_i) ? wmclh_pkg::QC_ZERO :
	               (osc_edge_i ? cnt_q + 12'h001 : cnt_q);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= wmclh_pkg::QC_ZERO;
			ok_o  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			ok_o  <= hit;
		end
	end

	chk_qc_full_count: assert property (@(posedge clk_i) disable iff (rst_i)
		ok_o |-> $past(cnt_q) == wmclh_pkg::QC_LAST && $past(osc_edge_i))
		else $error("quality check passed early");
endmodule // wmclh_qcheck

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic			clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0]		wb_adr_i, wb_sel_i;
	logic [31:0]	wb_dat_i, wb_dat_o, lfsr_q;
	logic			wait_mode_i, wakeup_irq_i, ext_reset_i, clock_monitor_fail_i;
	logic			oscillator_clock_i, clock_monitor_reset_o, reset_sequence_o, wait_exit_o;
	logic			self_clock_mode_o, pll_enable_o, voltage_regulator_o, system_clock_pll_o;
	logic			quality_run_o, irq_o, osc_run, exit_pll;
	logic [1:0]		osc_div;
	int				failures, tests_run, cmr_n, rseq_n, wait_n, r0;
	bit				q_rd[$];
	logic [31:0]	q_exp[$];

	wmclh_top wmclh_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.wait_mode_i(wait_mode_i), .wakeup_irq_i(wakeup_irq_i), .ext_reset_i(ext_reset_i),
		.clock_monitor_fail_i(clock_monitor_fail_i), .oscillator_clock_i(oscillator_clock_i),
		.clock_monitor_reset_o(clock_monitor_reset_o), .reset_sequence_o(reset_sequence_o),
		.wait_exit_o(wait_exit_o), .self_clock_mode_o(self_clock_mode_o),
		.pll_enable_o(pll_enable_o), .voltage_regulator_o(voltage_regulator_o),
		.system_clock_pll_o(system_clock_pll_o), .quality_run_o(quality_run_o), .irq_o(irq_o));

	always #2 clk_i = ~clk_i;

	// Oscillator at a quarter of the clock, half the fastest rate the pin sampler counts
	always @(posedge clk_i) begin
		osc_div <= osc_div + 2'h1;
		oscillator_clock_i <= osc_run & osc_div[1];
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Read results are compared when the ack arrives
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && q_rd.size() > 0) begin
			if (q_rd.pop_front())
				check(wb_dat_o, q_exp[0]);
			void'(q_exp.pop_front());
		end
		if (clock_monitor_reset_o === 1'b1)
			cmr_n++;
		if (reset_sequence_o === 1'b1)
			rseq_n++;
		if (wait_exit_o === 1'b1)
			exit_pll = system_clock_pll_o;
	end

	task automatic wb_op(input logic we, input logic [3:0] adr, input logic [3:0] dat,
			input logic [31:0] exp);
		int i;
		lfsr_q = lfsr_next(lfsr_q);
		q_rd.push_back(!we);
		q_exp.push_back(exp);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= {lfsr_q[3:1], 1'b1};
		wb_dat_i <= {lfsr_q[31:4], dat};
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 20);
		if (wb_ack_o !== 1'b1) begin
			failures++;
			$display("[FAIL] %0t bus acknowledge timed out", $time);
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic lose_clock(input logic [3:0] ctrl);
		wb_op(1'b1, wmclh_pkg::ADDR_STATUS, 4'hf, 32'h0);
		wb_op(1'b1, wmclh_pkg::ADDR_CTRL, ctrl, 32'h0);
		// Wait request is a pulse: a held level re-enters wait after each exit
		wait_mode_i <= 1'b1;
		clock_monitor_fail_i <= 1'b1;
		osc_run <= 1'b1;
		@(posedge clk_i);
		wait_mode_i <= 1'b0;
		repeat (7) @(posedge clk_i);
	endtask

	task automatic recover;
		clock_monitor_fail_i <= 1'b0;
		for (wait_n = 0; wait_n < 20000 && self_clock_mode_o !== 1'b0; wait_n++)
			@(posedge clk_i);
	endtask

	task automatic leave(input bit by_reset);
		int i;
		r0 = rseq_n;
		if (by_reset)
			ext_reset_i <= 1'b1;
		else
			wakeup_irq_i <= 1'b1;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (wait_exit_o !== 1'b1 && i < 50);
		check(32'(wait_exit_o === 1'b1), 32'h1);
		// Pulse counter updates on this same edge; let it settle first
		@(posedge clk_i);
		check(32'(rseq_n - r0), 32'(by_reset));
		wakeup_irq_i <= 1'b0;
		ext_reset_i <= 1'b0;
		wait_mode_i <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask

	task automatic finish_test;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge clk_i);
		failures++;
		finish_test();
	end

	initial begin
		{clk_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		{wait_mode_i, wakeup_irq_i, ext_reset_i, clock_monitor_fail_i, osc_run} = '0;
		{oscillator_clock_i, osc_div, exit_pll} = '0;
		{failures, tests_run, cmr_n, rseq_n} = '0;
		rst_i = 1'b1;
		lfsr_q = 32'hd797c42c;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb_op(1'b0, wmclh_pkg::ADDR_CTRL, 4'h0, 32'h0);
		wb_op(1'b0, wmclh_pkg::ADDR_MASK, 4'h0, 32'h0);
		wb_op(1'b0, 4'h2, 4'h0, 32'h0);
		check(32'({pll_enable_o, voltage_regulator_o, irq_o}), 32'h6);
		$display("test reset finished");

		lose_clock(4'h0);
		check(32'({self_clock_mode_o, pll_enable_o}), 32'h1);
		check(32'(cmr_n), 32'h0);
		wb_op(1'b0, wmclh_pkg::ADDR_STATUS, 4'h0, 32'h0);
		clock_monitor_fail_i <= 1'b0;
		leave(1'b0);
		$display("test monitor off finished");

		// Wait is entered once, so the monitor reset fires exactly once
		lose_clock(4'h1);
		clock_monitor_fail_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		check(32'(cmr_n), 32'h1);
		wb_op(1'b1, wmclh_pkg::ADDR_MASK, 4'h4, 32'h0);
		check(32'(irq_o), 32'h1);
		wb_op(1'b1, wmclh_pkg::ADDR_MASK, 4'h0, 32'h0);
		check(32'(irq_o), 32'h0);
		wb_op(1'b1, wmclh_pkg::ADDR_MASK, 4'h4, 32'h0);
		wb_op(1'b1, wmclh_pkg::ADDR_STATUS, 4'hf, 32'h0);
		check(32'(irq_o), 32'h0);
		wb_op(1'b1, wmclh_pkg::ADDR_MASK, 4'h0, 32'h0);
		// Reset has left wait: run state, PLL and regulator on
		wb_op(1'b0, wmclh_pkg::ADDR_STATE, 4'h0, 32'h60);
		check(32'(cmr_n), 32'h1);
		$display("test monitor reset finished");

		for (int k = 0; k < 2; k++) begin
			lose_clock(4'hb);
			check(32'({self_clock_mode_o, quality_run_o, pll_enable_o}), 32'h7);
			check(32'(voltage_regulator_o), 32'h1);
			wb_op(1'b0, wmclh_pkg::ADDR_STATUS, 4'h0, 32'h1);
			repeat (200) @(posedge clk_i);
			check(32'({self_clock_mode_o, quality_run_o}), 32'h3);
			recover();
			check(32'(wait_n >= 16380 && wait_n <= 16400), 32'h1);
			check(32'({self_clock_mode_o, pll_enable_o, voltage_regulator_o}), 32'h1);
			leave(k[0]);
			check(32'({exit_pll, system_clock_pll_o, irq_o}), 32'h0);
			wb_op(1'b0, wmclh_pkg::ADDR_STATUS, 4'h0, 32'hb);
			$display("test recovered exit finished");
		end

		for (int k = 0; k < 2; k++) begin
			// Second pass also enables the self-clock interrupt
			lose_clock(k[0] ? 4'h7 : 4'h3);
			check(32'(irq_o), 32'(k[0]));
			leave(k[0]);
			check(32'({exit_pll, system_clock_pll_o, quality_run_o}), 32'h7);
			recover();
			check(32'({system_clock_pll_o, quality_run_o}), 32'h0);
			$display("test lost exit finished");
		end
		finish_test();
	end
endmodule // tb_top
